// File: pkg/isl_pkg.sv
/*
  Package for the input supply lockout control block: register offsets,
  field positions, reset values and widths.
  Assumes a 32-bit APB slave with one aligned word per register.
*/
package isl_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] ISL_CTRL_OFS = 8'h00;
  localparam logic [7:0] ISL_UV_CODE_OFS = 8'h04;
  localparam logic [7:0] ISL_OV_CODE_OFS = 8'h08;
  localparam logic [7:0] ISL_IRQ_STAT_OFS = 8'h0c;
  localparam logic [7:0] ISL_IRQ_MASK_OFS = 8'h10;

  // ==========================================================================
  // Control register fields
  localparam int ISL_UV_EN_BIT = 7;
  localparam int ISL_UV_STAT_BIT = 6;
  localparam int ISL_UV_RISE_BIT = 5;
  localparam int ISL_UV_FALL_BIT = 4;
  localparam int ISL_OV_EN_BIT = 3;
  localparam int ISL_OV_STAT_BIT = 2;
  localparam int ISL_OV_RISE_BIT = 1;
  localparam int ISL_OV_FALL_BIT = 0;

  // ==========================================================================
  // Interrupt status and mask fields
  localparam int ISL_IRQ_UV_BIT = 0;
  localparam int ISL_IRQ_OV_BIT = 1;

  // ==========================================================================
  // Widths and reset values
  localparam int ISL_CODE_W = 6;
  localparam logic [7:0] ISL_CTRL_RST = 8'h00;
  localparam logic [5:0] ISL_CODE_RST = 6'h00;
  localparam logic [1:0] ISL_IRQ_RST = 2'h0;

endpackage : isl_pkg

// File: pkg/isl_cmp_if.sv
/*
  Interface carrying one comparator's sampled state and its edge events
  from the comparator front end to the register logic.
  Assumes both ends run on ref_clk.
*/
`timescale 1ns/1ps
interface isl_cmp_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : isl_cmp_if

// File: rtl/isl_cmp_sync.sv
/*
  Comparator front end: two-flop synchroniser and edge detector.
  Assumes an asynchronous comparator level and a synchronous high reset.
*/
`timescale 1ns/1ps
module isl_cmp_sync (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic cmp_async,
  isl_cmp_if.src cmp
);

  logic meta_r;
  logic sync_r;
  logic last_r;
  logic meta_nxt;
  logic sync_nxt;
  logic last_nxt;

  // ==========================================================================
  // Synchroniser and edge detect
  always_comb begin
    meta_nxt = cmp_async;
    sync_nxt = meta_r;
    last_nxt = sync_r;
  end

  // RQ15 two-flop sync
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      last_r <= last_nxt;
    end
  end

  assign cmp.level = sync_r;
  // RQ15 single edge event
  assign cmp.rise = sync_r & ~last_r;
  assign cmp.fall = ~sync_r & last_r;

endmodule : isl_cmp_sync

// File: rtl/isl_gate_hold.sv
/*
  Gate drive blocking stage: registers the lockout result that forces
  both gate-drive enables off.
  Assumes synchronised lockout levels from the same clock domain.
*/
`timescale 1ns/1ps
module isl_gate_hold (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic uv_block,
  input wire logic ov_block,
  input wire logic primary_req,
  input wire logic secondary_req,
  output logic primary_gate_drive,
  output logic secondary_gate_drive
);

  logic pri_r;
  logic sec_r;
  logic pri_nxt;
  logic sec_nxt;

  // ==========================================================================
  // Forced-off gating
  always_comb begin
    pri_nxt = primary_req & ~(uv_block | ov_block);
    sec_nxt = secondary_req & ~(uv_block | ov_block);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pri_r <= 1'b0;
      sec_r <= 1'b0;
    end else begin
      pri_r <= pri_nxt;
      sec_r <= sec_nxt;
    end
  end

  assign primary_gate_drive = pri_r;
  assign secondary_gate_drive = sec_r;

endmodule : isl_gate_hold

// File: rtl/isl_top.sv
/*
  Input supply lockout control: APB registers, comparator event flags,
  interrupt and gate-drive lockout.
  Assumes asynchronous comparator outputs (high = fault present) and an
  APB master on ref_clk at 200 MHz.
*/
// Design decisions made here: the register offsets and the APB register port.
// Contract
// RQ1 - Enabled undervoltage with supply below level turns both gate drives off.
// RQ2 - Enabled overvoltage with supply above level turns both gate drives off.
// RQ3 - Undervoltage indication clears itself once supply rises above level.
// RQ4 - Overvoltage indication clears itself once supply falls below level.
// RQ5 - Read-only undervoltage status bit, reset 0, shows present undervoltage.
// RQ6 - Read-only overvoltage status at control bit 2, reset 0.
// RQ7 - Edge flags set regardless of comparator enables or global interrupt enable.
// RQ8 - Undervoltage flag on rise if rise enable, on fall if fall enable.
// RQ9 - Overvoltage flag on rise if bit 1, on fall if bit 0.
// RQ10 - Control bit 7 enables undervoltage, bit 3 overvoltage; read/write, reset 0.
// RQ11 - Undervoltage code six bits read/write, bits 7 and 6 read zero.
// RQ12 - Overvoltage code six bits read/write, bits 7 and 6 read zero.
// RQ13 - Below range with core alive, comparator and status show undervoltage.
// RQ14 - Firmware should poll undervoltage status for power-up, advice only.
// RQ15 - Comparator outputs are synchronised before edge detection.
`timescale 1ns/1ps
module isl_top
  import isl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic uv_cmp_async,
  input wire logic ov_cmp_async,
  input wire logic primary_req,
  input wire logic secondary_req,
  output logic primary_gate_drive,
  output logic secondary_gate_drive,
  output logic [5:0] undervoltage_code_field,
  output logic [5:0] overvoltage_code_field,
  output logic irq
);

  isl_cmp_if uv_if ();
  isl_cmp_if ov_if ();

  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [5:0] uv_code_r;
  logic [5:0] uv_code_nxt;
  logic [5:0] ov_code_r;
  logic [5:0] ov_code_nxt;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_stat_nxt;
  logic [1:0] irq_mask_r;
  logic [1:0] irq_mask_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic wr_acc;
  logic rd_acc;
  logic hit;
  logic lo_lane;
  logic uv_event;
  logic ov_event;
  logic [7:0] ctrl_view;

  // ==========================================================================
  // Comparator front ends
  isl_cmp_sync u_uv_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .cmp_async(uv_cmp_async),
    .cmp(uv_if)
  );

  isl_cmp_sync u_ov_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .cmp_async(ov_cmp_async),
    .cmp(ov_if)
  );

  // ==========================================================================
  // Event qualification
  always_comb begin
    // RQ7 flags ignore enables
    // RQ8 undervoltage edge select
    uv_event = (uv_if.rise & ctrl_r[ISL_UV_RISE_BIT]) | (uv_if.fall & ctrl_r[ISL_UV_FALL_BIT]);
    // RQ9 overvoltage edge select
    ov_event = (ov_if.rise & ctrl_r[ISL_OV_RISE_BIT]) | (ov_if.fall & ctrl_r[ISL_OV_FALL_BIT]);
  end

  // ==========================================================================
  // Control view with live status bits
  always_comb begin
    ctrl_view = ctrl_r;
    // RQ5 undervoltage status
    // RQ13 below range shows fault
    // RQ3 clears with comparator
    ctrl_view[ISL_UV_STAT_BIT] = uv_if.level;
    // RQ6 overvoltage status
    // RQ4 clears with comparator
    ctrl_view[ISL_OV_STAT_BIT] = ov_if.level;
  end

  // ==========================================================================
  // APB decode
  always_comb begin
    wr_acc = psel & penable & pwrite;
    rd_acc = psel & ~penable & ~pwrite;
    lo_lane = pstrb[0];
    hit = (paddr == ISL_CTRL_OFS) | (paddr == ISL_UV_CODE_OFS) | (paddr == ISL_OV_CODE_OFS) |
          (paddr == ISL_IRQ_STAT_OFS) | (paddr == ISL_IRQ_MASK_OFS);
    pready = 1'b1;
    pslverr = psel & penable & ~hit;
  end

  // ==========================================================================
  // Register next state
  always_comb begin
    ctrl_nxt = ctrl_r;
    uv_code_nxt = uv_code_r;
    ov_code_nxt = ov_code_r;
    irq_mask_nxt = irq_mask_r;
    irq_stat_nxt = irq_stat_r;
    if (wr_acc && lo_lane) begin
      unique case (paddr)
        // RQ10 enables and edge selects writable
        ISL_CTRL_OFS: begin
          ctrl_nxt = pwdata[7:0];
        end
        // RQ11 undervoltage code
        ISL_UV_CODE_OFS: begin
          uv_code_nxt = pwdata[ISL_CODE_W-1:0];
        end
        // RQ12 overvoltage code
        ISL_OV_CODE_OFS: begin
          ov_code_nxt = pwdata[ISL_CODE_W-1:0];
        end
        ISL_IRQ_STAT_OFS: begin
          irq_stat_nxt = irq_stat_r & ~pwdata[1:0];
        end
        ISL_IRQ_MASK_OFS: begin
          irq_mask_nxt = pwdata[1:0];
        end
        default: begin
          ctrl_nxt = ctrl_r;
        end
      endcase
    end
    // Status bits are never stored
    ctrl_nxt[ISL_UV_STAT_BIT] = 1'b0;
    ctrl_nxt[ISL_OV_STAT_BIT] = 1'b0;
    // RQ7 set wins over clear
    if (uv_event) begin
      irq_stat_nxt[ISL_IRQ_UV_BIT] = 1'b1;
    end
    if (ov_event) begin
      irq_stat_nxt[ISL_IRQ_OV_BIT] = 1'b1;
    end
  end

  // ==========================================================================
  // Read data
  always_comb begin
    prdata_nxt = prdata_r;
    if (rd_acc) begin
      unique case (paddr)
        ISL_CTRL_OFS: prdata_nxt = {24'h000000, ctrl_view};
        // RQ11 upper bits read zero
        ISL_UV_CODE_OFS: prdata_nxt = {26'h0, uv_code_r};
        // RQ12 upper bits read zero
        ISL_OV_CODE_OFS: prdata_nxt = {26'h0, ov_code_r};
        ISL_IRQ_STAT_OFS: prdata_nxt = {30'h0, irq_stat_r};
        ISL_IRQ_MASK_OFS: prdata_nxt = {30'h0, irq_mask_r};
        default: prdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_r <= ISL_CTRL_RST;
      uv_code_r <= ISL_CODE_RST;
      ov_code_r <= ISL_CODE_RST;
      irq_stat_r <= ISL_IRQ_RST;
      irq_mask_r <= ISL_IRQ_RST;
      prdata_r <= 32'h00000000;
    end else begin
      ctrl_r <= ctrl_nxt;
      uv_code_r <= uv_code_nxt;
      ov_code_r <= ov_code_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;
  assign undervoltage_code_field = uv_code_r;
  assign overvoltage_code_field = ov_code_r;
  assign irq = |(irq_stat_r & irq_mask_r);

  // ==========================================================================
  // Gate drive lockout
  isl_gate_hold u_gate (
    .ref_clk(ref_clk),
    .srst(srst),
    // RQ1 undervoltage lockout
    .uv_block(ctrl_r[ISL_UV_EN_BIT] & uv_if.level),
    // RQ2 overvoltage lockout
    .ov_block(ctrl_r[ISL_OV_EN_BIT] & ov_if.level),
    .primary_req(primary_req),
    .secondary_req(secondary_req),
    .primary_gate_drive(primary_gate_drive),
    .secondary_gate_drive(secondary_gate_drive)
  );

endmodule : isl_top

// File: dv/isl_supply_model.sv
/* Supply comparators seen from the lockout block.
   Assumes vin in volts, set by the bench. */
`timescale 1ns/1ps
module isl_supply_model (
  input var real vin,
  input wire logic [5:0] undervoltage_code_field,
  input wire logic [5:0] overvoltage_code_field,
  output logic uv_cmp_async,
  output logic ov_cmp_async
);
  assign uv_cmp_async = vin < 3.5472 * (1.0285 ** undervoltage_code_field);
  assign ov_cmp_async = vin > 7.4847 * (1.0286 ** overvoltage_code_field);
endmodule : isl_supply_model

// File: dv/isl_monitor.sv
/* Port checker for the lockout block.
   Assumes one ref_clk domain, srst synchronous high. */
`timescale 1ns/1ps
module isl_monitor
  import isl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic uv_cmp_async,
  input wire logic ov_cmp_async,
  input wire logic primary_req,
  input wire logic primary_gate_drive,
  input wire logic secondary_gate_drive,
  input wire logic [5:0] undervoltage_code_field
);
  // ====
  // Shadow of control writes
  logic acc;
  logic rd_ctrl;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  assign acc = psel && penable;
  assign rd_ctrl = acc && !pwrite && paddr == ISL_CTRL_OFS;
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (acc && pwrite && pstrb[0] && paddr == ISL_CTRL_OFS) begin
      ctrl_nxt = pwdata[7:0];
    end
  end
  always_ff @(posedge ref_clk) begin
    ctrl_r <= srst ? 8'h00 : ctrl_nxt;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // ====
  // Assertions
  AST_UV_GATE: assert property (
    (ctrl_r[ISL_UV_EN_BIT] && uv_cmp_async)[*4] |-> !primary_gate_drive && !secondary_gate_drive)
    else $error("uv lockout left a drive on");
  AST_OV_GATE: assert property (
    (ctrl_r[ISL_OV_EN_BIT] && ov_cmp_async)[*4] |-> !primary_gate_drive && !secondary_gate_drive)
    else $error("ov lockout left a drive on");
  AST_GATE_PASS: assert property (
    (!uv_cmp_async && !ov_cmp_async)[*4] |-> primary_gate_drive == $past(primary_req))
    else $error("drive not following request");
  AST_UV_CODE: assert property (
    acc && pwrite && pstrb[0] && paddr == ISL_UV_CODE_OFS |=>
    {26'h0, undervoltage_code_field} == ($past(pwdata) & 32'h3f))
    else $error("uv code not written");
  AST_CODE_RD: assert property (
    acc && !pwrite && paddr == ISL_UV_CODE_OFS |-> prdata == {26'h0, undervoltage_code_field})
    else $error("uv code read wrong");
  AST_CTRL_RD: assert property (
    rd_ctrl |-> (prdata & 32'hffff_ffbb) == {24'h0, ctrl_r & 8'hbb})
    else $error("control read wrong");
  AST_UV_STAT: assert property (
    uv_cmp_async[*4] ##0 rd_ctrl |-> prdata[ISL_UV_STAT_BIT])
    else $error("uv status low");
  AST_OV_STAT: assert property (
    (!ov_cmp_async)[*4] ##0 rd_ctrl |-> !prdata[ISL_OV_STAT_BIT])
    else $error("ov status high");
endmodule : isl_monitor

// File: dv/input_supply_lockout_control_tb.sv
/* Self-checking bench for isl_top.
   Assumes package, interface, rtl and dv files compiled first. */
`timescale 1ns/1ps
module input_supply_lockout_control_tb
  import isl_pkg::*;
;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic primary_req = 1'b0;
  logic secondary_req = 1'b1;
  logic [31:0] prdata;
  logic pready, pslverr, uv_cmp_async, ov_cmp_async, primary_gate_drive, secondary_gate_drive, irq;
  logic [5:0] undervoltage_code_field, overvoltage_code_field;
  real vin = 6.0;
  logic [31:0] mask_v = 32'h3;
  int err_total = 0;
  int check_count = 0;
  isl_top i_dut (.*);
  isl_supply_model i_sup (.*);
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Opposite requests: exactly one drive on when unlocked
  always @(posedge ref_clk) begin
    primary_req <= ~primary_req;
    secondary_req <= primary_req;
  end
  // ====
  // Shared tasks
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    cmp(q, x);
  endtask : rd
  // Dip or surge of the supply and back to 9 V
  task automatic exc(input logic [7:0] c, input real v, input logic [7:0] st, input logic [31:0] fm,
                     input logic [31:0] fe, input logic [31:0] g);
    wr(ISL_CTRL_OFS, {24'h0, c});
    wr(ISL_IRQ_STAT_OFS, 32'h3);
    rd(ISL_IRQ_STAT_OFS, 32'h0);
    vin <= v;
    repeat (6) @(posedge ref_clk);
    rd(ISL_CTRL_OFS, {24'h0, c | st});
    rd(ISL_IRQ_STAT_OFS, fm);
    cmp({31'h0, irq}, {31'h0, |(fm & mask_v)});
    cmp({31'h0, primary_gate_drive | secondary_gate_drive}, g);
    vin <= 9.0;
    repeat (6) @(posedge ref_clk);
    rd(ISL_CTRL_OFS, {24'h0, c});
    rd(ISL_IRQ_STAT_OFS, fe);
    cmp({31'h0, primary_gate_drive | secondary_gate_drive}, 32'h1);
  endtask : exc
  // ====
  // Scenarios
  task automatic t_regs();
    logic [31:0] q;
    logic e;
    rd(ISL_CTRL_OFS, 32'h0);
    wr(ISL_CTRL_OFS, 32'hff);
    rd(ISL_CTRL_OFS, 32'hbb);
    wr(ISL_CTRL_OFS, 32'h0);
    wr(ISL_UV_CODE_OFS, 32'hff);
    rd(ISL_UV_CODE_OFS, 32'h3f);
    pstrb <= 4'he;
    wr(ISL_UV_CODE_OFS, 32'h00);
    pstrb <= 4'hf;
    rd(ISL_UV_CODE_OFS, 32'h3f);
    wr(ISL_OV_CODE_OFS, 32'hc5);
    rd(ISL_OV_CODE_OFS, 32'h05);
    cmp({26'h0, overvoltage_code_field}, 32'h05);
    apb(1'b0, 8'h40, 32'h0, q, e);
    cmp({q[30:0], e}, 32'h1);
    wr(ISL_UV_CODE_OFS, 32'h14);
    wr(ISL_OV_CODE_OFS, 32'h10);
    wr(ISL_IRQ_MASK_OFS, mask_v);
    vin <= 9.0;
    repeat (6) @(posedge ref_clk);
  endtask : t_regs
  task automatic t_uv();
    exc(8'ha0, 5.0, 8'h40, 32'h1, 32'h1, 32'h0);
    exc(8'h10, 5.0, 8'h40, 32'h0, 32'h1, 32'h1);
    exc(8'h80, 1.0, 8'h40, 32'h0, 32'h0, 32'h0);
  endtask : t_uv
  task automatic t_ov();
    exc(8'h0a, 12.5, 8'h04, 32'h2, 32'h2, 32'h0);
    exc(8'h01, 12.5, 8'h04, 32'h0, 32'h2, 32'h1);
  endtask : t_ov
  task automatic t_mask();
    mask_v = 32'h0;
    wr(ISL_IRQ_MASK_OFS, mask_v);
    exc(8'h30, 5.0, 8'h40, 32'h1, 32'h1, 32'h1);
    mask_v = 32'h3;
    wr(ISL_IRQ_MASK_OFS, mask_v);
    cmp({31'h0, irq}, 32'h1);
    wr(ISL_IRQ_STAT_OFS, 32'h1);
    cmp({31'h0, irq}, 32'h0);
  endtask : t_mask
  task automatic test_done();
    if (err_total == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    t_regs();
    t_uv();
    t_ov();
    t_mask();
    test_done();
  end
  initial begin
    #20000;
    err_total++;
    test_done();
  end
endmodule : input_supply_lockout_control_tb
bind isl_top isl_monitor i_mon (.*);
